// ===== rtl/srch_pkg.sv
// Shared constants and types of the sector read command handler.
// Assumes one device clock; host task-file strobes are synchronous to it.
package srch_pkg;
   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_BUF_PIO = 8'he4;
   localparam logic [7:0] CMD_BUF_DMA = 8'he9;
   localparam logic [7:0] CMD_MED_DMA = 8'hc8;
   // ----------------------------------------
   // Task-file offsets
   // ----------------------------------------
   localparam logic [2:0] TF_DATA = 3'h0;
   localparam logic [2:0] TF_ERR = 3'h1;
   localparam logic [2:0] TF_CNT = 3'h2;
   localparam logic [2:0] TF_SECN = 3'h3;
   localparam logic [2:0] TF_CYLL = 3'h4;
   localparam logic [2:0] TF_CYLH = 3'h5;
   localparam logic [2:0] TF_DEVH = 3'h6;
   localparam logic [2:0] TF_STAT = 3'h7;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int ER_UNC = 6;
   localparam int ER_IDNF = 4;
   localparam int ER_ABT = 2;
   localparam int DEVH_LBA = 6;
   // ----------------------------------------
   // Reset values and sizes
   // ----------------------------------------
   localparam logic [7:0] TF_RST = 8'h00;
   localparam logic [7:0] ERR_RST = 8'h00;
   localparam logic [7:0] LAST_WORD = 8'hff;
   localparam logic [8:0] ZERO_CNT_SECTORS = 9'h100;
   localparam logic [7:0] SECTORS_PER_TRACK = 8'h3f;
   localparam logic [3:0] LAST_HEAD = 4'hf;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] secn;
      logic [7:0] cyll;
      logic [7:0] cylh;
      logic [7:0] devh;
   } srch_tf_t;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_PIO = 3'b001,
      S_BDMA = 3'b010,
      S_MREQ = 3'b011,
      S_MFILL = 3'b100,
      S_MDMA = 3'b101
   } srch_state_t;
endpackage

// ===== rtl/srch_sector_buf.sv
// One-sector buffer of 16-bit words with a registered read port.
// Assumes the writer and reader share clk_i.
`timescale 1ns/1ps
module srch_sector_buf
   import srch_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Write port
   input wire logic we_i,
   input wire logic [7:0] waddr_i,
   input wire logic [15:0] wdata_i,
   // Read port
   input wire logic [7:0] raddr_i,
   output logic [15:0] rdata_o
);
   logic [15:0] mem [0:255];

   // ----------------------------------------
   // Storage, no reset so it maps to RAM
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // Read word follows the address one cycle later
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rdata_o <= 16'h0000;
      end
      else
      begin
         rdata_o <= mem[raddr_i];
      end
   end
endmodule // srch_sector_buf

// ===== rtl/srch_handler.sv
// Read command handler: buffer PIO, buffer DMA and media DMA reads.
// Assumes host strobes, media stream and DMA acknowledge are on clk_i.
`timescale 1ns/1ps
module srch_handler
   import srch_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Task-file register port
   input wire logic [2:0] tf_addr_i,
   input wire logic tf_wr_i,
   input wire logic tf_rd_i,
   input wire logic [7:0] tf_wdata_i,
   output logic [7:0] tf_rdata_o,
   // Data register, PIO and DMA
   input wire logic data_rd_i,
   input wire logic dmack_i,
   output logic [15:0] data_o,
   output logic dmarq_o,
   output logic intrq_o,
   // Write-buffer fill port
   input wire logic wbuf_we_i,
   input wire logic [7:0] wbuf_addr_i,
   input wire logic [15:0] wbuf_data_i,
   // Media stream
   output logic media_req_o,
   output logic media_lba_o,
   output logic [27:0] media_addr_o,
   input wire logic media_vld_i,
   input wire logic [15:0] media_data_i,
   input wire logic media_unc_i,
   input wire logic media_idnf_i
);
   srch_state_t state_reg, state_next;
   srch_tf_t tf_reg, tf_next;
   logic [7:0] err_reg, err_next;
   logic errf_reg, errf_next;
   logic intr_reg, intr_next;
   logic [8:0] remain_reg, remain_next;
   logic [7:0] ptr_reg, ptr_next;
   logic [7:0] rd_reg, rd_next;
   logic mreq_reg, mreq_next;
   logic dmarq_reg, dmarq_next;
   logic engaged;
   logic dma_take;
   logic med_fault;
   logic buf_we;
   logic [7:0] buf_waddr;
   logic [15:0] buf_wdata;
   logic [7:0] status;

   // ----------------------------------------
   // Address advance for the next sector
   // ----------------------------------------
   function automatic srch_tf_t advance(input srch_tf_t t);
      srch_tf_t r;
      r = t;
      if (t.devh[DEVH_LBA])
      begin
         {r.devh[3:0], r.cylh, r.cyll, r.secn} =
            28'({t.devh[3:0], t.cylh, t.cyll, t.secn} + 28'h0000001);
      end
      else if (t.secn != SECTORS_PER_TRACK)
      begin
         r.secn = 8'(t.secn + 8'h01);
      end
      else
      begin
         r.secn = 8'h01;
         r.devh[3:0] = (t.devh[3:0] == LAST_HEAD) ? 4'h0 : 4'(t.devh[3:0] + 4'h1);
         if (t.devh[3:0] == LAST_HEAD)
         begin
            {r.cylh, r.cyll} = 16'({t.cylh, t.cyll} + 16'h0001);
         end
      end
      return r;
   endfunction

   // ----------------------------------------
   // Derived status
   // ----------------------------------------
   assign engaged = (state_reg == S_BDMA) || (state_reg == S_MREQ) ||
                    (state_reg == S_MFILL) || (state_reg == S_MDMA);
   assign dma_take = dmack_i && dmarq_reg;
   assign med_fault = media_unc_i || media_idnf_i;
   assign status = {engaged, 1'b1, 1'b0, 1'b1, (state_reg == S_PIO), 2'b00, errf_reg};

   // Media fills the buffer, so later buffer reads see media data
   assign buf_we = (state_reg == S_MFILL) ? (media_vld_i && !med_fault) : wbuf_we_i;
   assign buf_waddr = (state_reg == S_MFILL) ? ptr_reg : wbuf_addr_i;
   assign buf_wdata = (state_reg == S_MFILL) ? media_data_i : wbuf_data_i;

   // ----------------------------------------
   // Command sequencing
   // ----------------------------------------
   always_comb
   begin
      state_next = state_reg;
      tf_next = tf_reg;
      err_next = err_reg;
      errf_next = errf_reg;
      intr_next = intr_reg;
      remain_next = remain_reg;
      ptr_next = ptr_reg;
      rd_next = rd_reg;
      mreq_next = 1'b0;
      // Register reads; status read drops the interrupt
      if (tf_rd_i)
      begin
         unique case (tf_addr_i)
            TF_DATA: rd_next = data_o[7:0];
            TF_ERR: rd_next = err_reg;
            TF_CNT: rd_next = tf_reg.cnt;
            TF_SECN: rd_next = tf_reg.secn;
            TF_CYLL: rd_next = tf_reg.cyll;
            TF_CYLH: rd_next = tf_reg.cylh;
            TF_DEVH: rd_next = tf_reg.devh;
            TF_STAT:
            begin
               rd_next = status;
               intr_next = 1'b0;
            end
         endcase
      end
      unique case (state_reg)
         S_IDLE:
         begin
            // Writes while a command runs are dropped
            if (tf_wr_i)
            begin
               unique case (tf_addr_i)
                  TF_DATA, TF_ERR: ;
                  TF_CNT: tf_next.cnt = tf_wdata_i;
                  TF_SECN: tf_next.secn = tf_wdata_i;
                  TF_CYLL: tf_next.cyll = tf_wdata_i;
                  TF_CYLH: tf_next.cylh = tf_wdata_i;
                  TF_DEVH: tf_next.devh = tf_wdata_i;
                  TF_STAT:
                  begin
                     err_next = ERR_RST;
                     errf_next = 1'b0;
                     ptr_next = 8'h00;
                     if (tf_wdata_i == CMD_BUF_PIO)
                     begin
                        state_next = S_PIO;
                        intr_next = 1'b1;
                     end
                     else if (tf_wdata_i == CMD_BUF_DMA)
                     begin
                        state_next = S_BDMA;
                     end
                     else if (tf_wdata_i[7:1] == CMD_MED_DMA[7:1])
                     begin
                        state_next = S_MREQ;
                        remain_next = (tf_reg.cnt == 8'h00) ? ZERO_CNT_SECTORS :
                                      {1'b0, tf_reg.cnt};
                     end
                     else
                     begin
                        err_next[ER_ABT] = 1'b1;
                        errf_next = 1'b1;
                        intr_next = 1'b1;
                     end
                  end
               endcase
            end
         end
         S_PIO:
         begin
            if (data_rd_i)
            begin
               ptr_next = 8'(ptr_reg + 8'h01);
               if (ptr_reg == LAST_WORD)
               begin
                  state_next = S_IDLE;
               end
            end
         end
         S_BDMA:
         begin
            if (dma_take)
            begin
               ptr_next = 8'(ptr_reg + 8'h01);
               if (ptr_reg == LAST_WORD)
               begin
                  state_next = S_IDLE;
                  intr_next = 1'b1;
               end
            end
         end
         S_MREQ:
         begin
            mreq_next = 1'b1;
            ptr_next = 8'h00;
            state_next = S_MFILL;
         end
         S_MFILL:
         begin
            if (med_fault)
            begin
               err_next[ER_UNC] = media_unc_i;
               err_next[ER_IDNF] = media_idnf_i;
               errf_next = 1'b1;
               tf_next.cnt = remain_reg[7:0];
               state_next = S_IDLE;
               intr_next = 1'b1;
            end
            else if (media_vld_i)
            begin
               ptr_next = 8'(ptr_reg + 8'h01);
               if (ptr_reg == LAST_WORD)
               begin
                  state_next = S_MDMA;
               end
            end
         end
         S_MDMA:
         begin
            if (dma_take)
            begin
               ptr_next = 8'(ptr_reg + 8'h01);
               if (ptr_reg == LAST_WORD)
               begin
                  remain_next = 9'(remain_reg - 9'h001);
                  if (remain_reg == 9'h001)
                  begin
                     tf_next.cnt = 8'h00;
                     state_next = S_IDLE;
                     intr_next = 1'b1;
                  end
                  else
                  begin
                     tf_next = advance(tf_reg);
                     tf_next.cnt = tf_reg.cnt;
                     state_next = S_MREQ;
                  end
               end
            end
         end
         default:
         begin
            state_next = S_IDLE;
         end
      endcase
      dmarq_next = (state_next == S_BDMA) || (state_next == S_MDMA);
   end

   // Register stage for the sequencer
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_reg <= S_IDLE;
         tf_reg <= {5{TF_RST}};
         err_reg <= ERR_RST;
         errf_reg <= 1'b0;
         intr_reg <= 1'b0;
         remain_reg <= 9'h000;
         ptr_reg <= 8'h00;
         rd_reg <= 8'h00;
         mreq_reg <= 1'b0;
         dmarq_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         tf_reg <= tf_next;
         err_reg <= err_next;
         errf_reg <= errf_next;
         intr_reg <= intr_next;
         remain_reg <= remain_next;
         ptr_reg <= ptr_next;
         rd_reg <= rd_next;
         mreq_reg <= mreq_next;
         dmarq_reg <= dmarq_next;
      end
   end

   // ----------------------------------------
   // Sector buffer and outputs
   // ----------------------------------------
   // Read address runs one ahead so data_o always holds word ptr_reg
   srch_sector_buf u_buf (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .we_i(buf_we),
      .waddr_i(buf_waddr),
      .wdata_i(buf_wdata),
      .raddr_i(ptr_next),
      .rdata_o(data_o)
   );

   assign tf_rdata_o = rd_reg;
   assign dmarq_o = dmarq_reg;
   assign intrq_o = intr_reg;
   assign media_req_o = mreq_reg;
   assign media_lba_o = tf_reg.devh[DEVH_LBA];
   assign media_addr_o = {tf_reg.devh[3:0], tf_reg.cylh, tf_reg.cyll, tf_reg.secn};

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   logic cmd_wr;
   assign cmd_wr = tf_wr_i && (tf_addr_i == TF_STAT) && (state_reg == S_IDLE);

   property p_pio_start;
      cmd_wr && (tf_wdata_i == CMD_BUF_PIO) |=> (state_reg == S_PIO) && intrq_o && !dmarq_o;
   endproperty
   a_pio_start: assert property (p_pio_start) else $error("pio buffer read not started");

   property p_bdma_start;
      cmd_wr && (tf_wdata_i == CMD_BUF_DMA) |=> dmarq_o && engaged;
   endproperty
   a_bdma_start: assert property (p_bdma_start) else $error("buffer dma not requested");

   property p_med_start;
      cmd_wr && (tf_wdata_i[7:1] == CMD_MED_DMA[7:1]) |-> ##2 media_req_o;
   endproperty
   a_med_start: assert property (p_med_start) else $error("media read not requested");

   property p_zero_count;
      cmd_wr && (tf_wdata_i[7:1] == CMD_MED_DMA[7:1]) && (tf_reg.cnt == 8'h00) |=>
         remain_reg == ZERO_CNT_SECTORS;
   endproperty
   a_zero_count: assert property (p_zero_count) else $error("zero count not 256");

   property p_pio_word;
      (state_reg == S_PIO) && data_rd_i |=> ptr_reg == 8'($past(ptr_reg) + 8'h01);
   endproperty
   a_pio_word: assert property (p_pio_word) else $error("pio word pointer stuck");

   property p_dma_paced;
      dmarq_o |-> (state_reg == S_BDMA) || (state_reg == S_MDMA);
   endproperty
   a_dma_paced: assert property (p_dma_paced) else $error("dma request outside transfer");

   property p_med_done;
      (state_reg == S_MDMA) && dma_take && (ptr_reg == LAST_WORD) && (remain_reg == 9'h001)
         |=> intrq_o && !engaged && (tf_reg.cnt == 8'h00) && !dmarq_o;
   endproperty
   a_med_done: assert property (p_med_done) else $error("media completion wrong");

   property p_unc_stop;
      (state_reg == S_MFILL) && media_unc_i |=>
         (state_reg == S_IDLE) && errf_reg && err_reg[ER_UNC] &&
         (tf_reg.cnt == $past(remain_reg[7:0])) ##1 !dmarq_o;
   endproperty
   a_unc_stop: assert property (p_unc_stop) else $error("read not stopped on error");

   property p_abort;
      cmd_wr && (tf_wdata_i != CMD_BUF_PIO) && (tf_wdata_i != CMD_BUF_DMA) &&
         (tf_wdata_i[7:1] != CMD_MED_DMA[7:1]) |=> err_reg[ER_ABT] && errf_reg && !engaged;
   endproperty
   a_abort: assert property (p_abort) else $error("unknown command not aborted");

   c_pio: cover property ((state_reg == S_PIO) ##1 (state_reg == S_IDLE));
   c_bdma: cover property ((state_reg == S_BDMA) ##1 (state_reg == S_IDLE));
   c_multi: cover property ((state_reg == S_MDMA) ##1 (state_reg == S_MREQ));
   c_unc: cover property ((state_reg == S_MFILL) && media_unc_i);
endmodule // srch_handler

// ===== tb/srch_media_model.sv
// Media side stand-in: answers each sector fetch with 256 words, with gaps; a faulted sector stops after 8.
// Assumes fetch requests are one-cycle pulses on clk_i, spaced by a full sector.
`timescale 1ns/1ps
module srch_media_model
   import srch_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Fetch request from the handler
   input wire logic media_req_i,
   input wire logic [27:0] media_addr_i,
   // Fault injection from the bench
   input wire logic [27:0] err_addr_i,
   input wire logic [1:0] err_kind_i,
   // Word stream back to the handler
   output logic media_vld_o,
   output logic [15:0] media_data_o,
   output logic media_unc_o,
   output logic media_idnf_o
);
   // ------
   // Sector source
   // ------
   // Word value is sector low byte and word index, so the bench can predict it
   initial
   begin
      logic [27:0] a;
      int i;
      media_vld_o = 1'b0;
      media_data_o = 16'h0000;
      media_unc_o = 1'b0;
      media_idnf_o = 1'b0;
      forever
      begin
         @(posedge clk_i);
         if (arst_n_i === 1'b1 && media_req_i === 1'b1)
         begin
            a = media_addr_i;
            i = 0;
            while (i < 256)
            begin
               @(negedge clk_i);
               // Idle data line flips so a stale word never looks valid
               if (err_kind_i != 2'h0 && a == err_addr_i && i == 8)
               begin
                  media_vld_o = 1'b0;
                  media_unc_o = (err_kind_i == 2'h1);
                  media_idnf_o = (err_kind_i == 2'h2);
                  media_data_o = ~media_data_o;
                  i = 256;
               end
               else if ($urandom_range(3) != 0)
               begin
                  media_vld_o = 1'b1;
                  media_data_o = {a[7:0], 8'(i)};
                  i++;
               end
               else
               begin
                  media_vld_o = 1'b0;
                  media_data_o = ~media_data_o;
               end
            end
            @(negedge clk_i);
            media_vld_o = 1'b0;
            media_unc_o = 1'b0;
            media_idnf_o = 1'b0;
            media_data_o = ~media_data_o;
         end
      end
   end
endmodule // srch_media_model

// ===== tb/sector_read_command_handler_tb.sv
// Self-checking bench of the read command handler, acting as host and DMA.
// Assumes the media stand-in and the package of the handler.
`timescale 1ns/1ps
module sector_read_command_handler_tb;
   import srch_pkg::*;
   // ------
   // Signals
   // ------
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [2:0] tf_addr_i = 3'h0;
   logic tf_wr_i = 1'b0;
   logic tf_rd_i = 1'b0;
   logic [7:0] tf_wdata_i = 8'h00;
   logic [7:0] tf_rdata_o;
   logic data_rd_i = 1'b0;
   logic dmack_i = 1'b0;
   logic [15:0] data_o;
   logic dmarq_o, intrq_o, media_req_o, media_lba_o;
   logic wbuf_we_i = 1'b0;
   logic [7:0] wbuf_addr_i = 8'h00;
   logic [15:0] wbuf_data_i = 16'h0000;
   logic [27:0] media_addr_o;
   logic media_vld_i, media_unc_i, media_idnf_i;
   logic [15:0] media_data_i;
   logic [27:0] err_addr = 28'h0;
   logic [1:0] err_kind = 2'h0;
   logic [27:0] exp_a = 28'h0;
   logic exp_l = 1'b0;
   logic irq_d = 1'b0;
   logic [15:0] exp_q[$];
   logic [15:0] wb[256];
   int fails = 0;
   int n_compared = 0;
   int n_irq = 0;

   // ------
   // Design and media stand-in
   // ------
   srch_handler DUT (.clk_i, .arst_n_i, .tf_addr_i, .tf_wr_i, .tf_rd_i, .tf_wdata_i,
      .tf_rdata_o, .data_rd_i, .dmack_i, .data_o, .dmarq_o, .intrq_o, .wbuf_we_i,
      .wbuf_addr_i, .wbuf_data_i, .media_req_o, .media_lba_o, .media_addr_o,
      .media_vld_i, .media_data_i, .media_unc_i, .media_idnf_i);
   srch_media_model media (.clk_i, .arst_n_i, .media_req_i(media_req_o),
      .media_addr_i(media_addr_o), .err_addr_i(err_addr), .err_kind_i(err_kind),
      .media_vld_o(media_vld_i), .media_data_o(media_data_i),
      .media_unc_o(media_unc_i), .media_idnf_o(media_idnf_i));

   // 40 MHz clock
   initial
   begin
      forever #12.5 clk_i = ~clk_i;
   end

   // Interrupt edges and fetch addresses watched on every rising edge
   always @(posedge clk_i)
   begin
      irq_d <= intrq_o;
      if (intrq_o === 1'b1 && irq_d !== 1'b1)
         n_irq++;
      if (media_req_o === 1'b1)
      begin
         chk(32'(media_addr_o), 32'(exp_a));
         chk(32'(media_lba_o), 32'(exp_l));
         exp_a = nxt(exp_a, exp_l);
      end
   end

   // ------
   // Tasks
   // ------
   task automatic wrap_up();
      if (fails == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Next sector address: linear in block mode, sector/head/cylinder otherwise
   function automatic logic [27:0] nxt(input logic [27:0] x, input logic l);
      logic [27:0] r;
      r = 28'(x + 28'h0000001);
      if (!l)
      begin
         r = x;
         if (x[7:0] != SECTORS_PER_TRACK)
            r[7:0] = 8'(x[7:0] + 8'h01);
         else
         begin
            r[7:0] = 8'h01;
            r[27:24] = 4'(x[27:24] + 4'h1);
            if (x[27:24] == LAST_HEAD)
               r[23:8] = 16'(x[23:8] + 16'h0001);
         end
      end
      return r;
   endfunction

   task automatic tf_wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk_i);
      tf_addr_i = a;
      tf_wdata_i = d;
      tf_wr_i = 1'b1;
      @(negedge clk_i);
      tf_wr_i = 1'b0;
   endtask

   // Read data is registered, so it is taken one edge after the strobe
   task automatic tf_chk(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] m);
      @(negedge clk_i);
      tf_addr_i = a;
      tf_rd_i = 1'b1;
      @(negedge clk_i);
      tf_rd_i = 1'b0;
      chk(32'(tf_rdata_o & m), 32'(exp));
   endtask

   // Word pump: PIO strobes at will, DMA acks only while requested
   task automatic take(input int n, input bit pio);
      int k;
      int g;
      bit go;
      k = 0;
      g = 0;
      while (k < n && g < 20000)
      begin
         @(negedge clk_i);
         g++;
         go = (pio || dmarq_o === 1'b1) && $urandom_range(2) != 0;
         if (go)
            chk(32'(data_o), 32'(exp_q.pop_front()));
         k += go;
         dmack_i = go && !pio;
         data_rd_i = go && pio;
      end
      @(negedge clk_i);
      dmack_i = 1'b0;
      data_rd_i = 1'b0;
      if (g >= 20000)
      begin
         fails++;
         wrap_up();
      end
   endtask

   task automatic med(input logic [7:0] cmd, input logic [7:0] cnt, input logic [27:0] a,
      input logic lba, input int ei, input logic [1:0] ek);
      int tot;
      int nx;
      int g;
      logic [27:0] last;
      logic [27:0] s;
      tot = (cnt == 8'h00) ? 256 : cnt;
      nx = (ek != 2'h0) ? ei : tot;
      exp_a = a;
      exp_l = lba;
      // Failing sector on error, else last sector of the run
      last = a;
      for (int j = 0; j < ((ek != 2'h0) ? ei : tot - 1); j++)
         last = nxt(last, lba);
      err_addr = last;
      err_kind = ek;
      s = a;
      for (int j = 0; j < nx; j++)
      begin
         for (int i = 0; i < 256; i++)
            exp_q.push_back({s[7:0], 8'(i)});
         s = nxt(s, lba);
      end
      n_irq = 0;
      tf_wr(TF_CNT, cnt);
      tf_wr(TF_SECN, a[7:0]);
      tf_wr(TF_CYLL, a[15:8]);
      tf_wr(TF_CYLH, a[23:16]);
      tf_wr(TF_DEVH, {1'b1, lba, 2'b10, a[27:24]});
      // DMA side starts right after the command goes out, before any request
      tf_wr(TF_STAT, cmd);
      take(nx * 256, 1'b0);
      g = 0;
      while (intrq_o !== 1'b1 && g < 2000)
      begin
         @(negedge clk_i);
         g++;
      end
      chk(32'(g < 2000), 32'd1);
      if (g >= 2000)
         wrap_up();
      chk(32'(dmarq_o), 32'd0);
      tf_chk(TF_STAT, (ek != 2'h0) ? 8'h51 : 8'h50, 8'hff);
      tf_chk(TF_ERR, (ek == 2'h1) ? 8'h40 : (ek == 2'h2) ? 8'h10 : 8'h00, 8'hff);
      tf_chk(TF_CNT, 8'(tot - nx), 8'hff);
      tf_chk(TF_SECN, last[7:0], 8'hff);
      tf_chk(TF_CYLL, last[15:8], 8'hff);
      tf_chk(TF_CYLH, last[23:16], 8'hff);
      tf_chk(TF_DEVH, {4'h0, last[27:24]}, 8'h0f);
      repeat (20) @(negedge clk_i);
      chk(32'(n_irq), 32'd1);
   endtask

   // ------
   // Main sequence
   // ------
   initial
   begin
      void'($urandom(32'h5aba));
      repeat (16) @(negedge clk_i);
      arst_n_i = 1'b1;
      tf_chk(TF_STAT, 8'h50, 8'hff);
      tf_chk(TF_ERR, ERR_RST, 8'hff);
      // Random sector through the write-buffer port
      for (int i = 0; i < 256; i++)
      begin
         @(negedge clk_i);
         wbuf_we_i = 1'b1;
         wbuf_addr_i = 8'(i);
         wbuf_data_i = 16'($urandom);
         wb[i] = wbuf_data_i;
      end
      @(negedge clk_i);
      wbuf_we_i = 1'b0;
      // Same buffer sector by PIO, then by DMA
      for (int p = 1; p >= 0; p--)
      begin
         n_irq = 0;
         for (int i = 0; i < 256; i++)
            exp_q.push_back(wb[i]);
         tf_wr(TF_CNT, 8'h11);
         tf_wr(TF_STAT, p ? CMD_BUF_PIO : CMD_BUF_DMA);
         if (p)
            tf_chk(TF_STAT, 8'h58, 8'hff);
         // Write during the data phase must be dropped
         tf_wr(TF_CNT, 8'haa);
         take(256, 1'(p));
         repeat (4) @(negedge clk_i);
         tf_chk(TF_STAT, 8'h50, 8'hff);
         tf_chk(TF_ERR, 8'h00, 8'hff);
         tf_chk(TF_CNT, 8'h11, 8'hff);
         chk(32'(n_irq), 32'd1);
      end
      // Unknown code is aborted
      tf_wr(TF_STAT, 8'h77);
      repeat (3) @(negedge clk_i);
      chk(32'(intrq_o), 32'd1);
      tf_chk(TF_STAT, 8'h51, 8'hff);
      tf_chk(TF_ERR, 8'h04, 8'hff);
      // Media reads: CHS across track, head and cylinder, LBA with carry, faults
      med(8'hc9, 8'h02, {4'hf, 8'h12, 8'h34, 8'h3f}, 1'b0, 0, 2'h0);
      med(CMD_MED_DMA, 8'h02, 28'h70201ff, 1'b1, 0, 2'h0);
      med(CMD_MED_DMA, 8'h03, 28'h0000010, 1'b1, 1, 2'h1);
      med(8'hc9, 8'h00, 28'h0000020, 1'b1, 2, 2'h1);
      med(8'hc9, 8'h01, 28'h0000030, 1'b1, 0, 2'h2);
      wrap_up();
   end
endmodule // sector_read_command_handler_tb
